// *** bench/flic_cpu_model.sv ***
// Sequencer model facing the controller: final-cycle flag and returns.
// Assumes the controller's phase output and return requests from the bench.
`timescale 1ns/1ps
`default_nettype none
module flic_cpu_model (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Controls from the bench.
    input wire logic slow,
    input wire logic irq_return_req,
    // Controller side.
    input wire logic [3:0] phase,
    output flic_pkg::flic_cpu_s cpu
);
    logic odd_r;
    // Slow mode runs two-cycle instructions, so half the polls are early.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            odd_r <= 1'b0;
            cpu <= '0;
        end else begin
            if (phase == flic_pkg::PH_LAST) begin
                odd_r <= !odd_r;
                cpu.last_cycle <= !slow || odd_r;
            end
            cpu.return_from_interrupt <= irq_return_req;
        end
    end
endmodule : flic_cpu_model
`default_nettype wire

// *** bench/flic_monitor.sv ***
// Checker for the four-level interrupt controller ports.
// Bound to flic_ctrl; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module flic_monitor (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Watched ports.
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [3:0] phase,
    input wire flic_pkg::flic_src_s src,
    input wire flic_pkg::flic_cpu_s cpu,
    input wire flic_pkg::flic_call_s call,
    input wire logic usb_hw_reset
);
    default clocking mc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [5:0] len_r;
    logic [5:0] len_nxt;
    // Counts the clocks a forced call has been running.
    always_comb len_nxt = call.long_call ? len_r + 6'h01 : 6'h00;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) len_r <= 6'h00;
        else len_r <= len_nxt;
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_push_start: assert property (
        $rose(call.long_call) |-> call.push_pc)
        else $error("call began without a push");
    chk_push_single: assert property (
        call.push_pc |=> !call.push_pc && call.long_call)
        else $error("push not a single pulse inside a call");
    chk_call_length: assert property (
        $fell(call.long_call) |-> len_r == 6'h18)
        else $error("call did not last two machine cycles");
    chk_vec_layout: assert property (call.push_pc |->
        call.vector[23:16] == flic_pkg::VEC_PAGE &&
        call.vector[2:0] == 3'h3 && call.vector[15:3] <= 13'h00a)
        else $error("vector not on an eight byte slot");
    chk_final_cycle: assert property ($rose(call.long_call) |->
        $past(cpu.last_cycle) && !$past(cpu.return_from_interrupt))
        else $error("call began outside a final cycle");
    chk_pop_return: assert property (
        cpu.return_from_interrupt |=> call.pop_pc)
        else $error("return did not pop the counter");
    chk_pop_cause: assert property (
        call.pop_pc |-> $past(cpu.return_from_interrupt))
        else $error("pop without a return");
    chk_usb_reset: assert property (src.usb_bus_reset |=> usb_hw_reset)
        else $error("bus reset not passed to usb hardware");
    chk_phase_wrap: assert property (
        phase == flic_pkg::PH_LAST |=> phase == 4'h0)
        else $error("machine cycle did not wrap");
endmodule : flic_monitor
bind flic_ctrl flic_monitor chk_u (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .phase(phase), .src(src),
    .cpu(cpu), .call(call), .usb_hw_reset(usb_hw_reset));
`default_nettype wire

// *** bench/tb_four_level_interrupt_controller.sv ***
// Self-checking bench for the interrupt controller.
// Assumes the checker is bound and the sequencer model drives cpu.
`timescale 1ns/1ps
`default_nettype none
module tb_four_level_interrupt_controller;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, usb_hw_reset;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [3:0] phase;
    logic pin_a_n = 1'b1;
    logic pin_b_n = 1'b1;
    logic slow = 1'b0;
    logic pin_k_n = 1'b1;
    logic irq_return_req = 1'b0;
    flic_pkg::flic_src_s src = '0;
    flic_pkg::flic_cpu_s cpu;
    flic_pkg::flic_call_s call;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] regs [7] = '{flic_pkg::IDX_ENABLE_A, flic_pkg::IDX_ENABLE_B,
        flic_pkg::IDX_PRIO_HI_A, flic_pkg::IDX_PRIO_LO_A,
        flic_pkg::IDX_PRIO_HI_B, flic_pkg::IDX_PRIO_LO_B, flic_pkg::IDX_STAT};

    // The one slave's ready is the bus ready.
    assign hready = hreadyout;
    always #4 hclk = ~hclk;

    flic_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_request_pin_a_n(pin_a_n),
        .ext_request_pin_b_n(pin_b_n), .keyboard_request_pin_n(pin_k_n),
        .src(src), .cpu(cpu), .call(call), .usb_hw_reset(usb_hw_reset),
        .phase(phase));
    flic_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .irq_return_req(irq_return_req), .phase(phase), .cpu(cpu));

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Compares one word and counts it.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk_word

    // One single AHB-Lite transfer; read data is kept in rd.
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    // Reads a register and compares it.
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        chk_word(rd, exp);
    endtask : rdchk

    // Watches for a forced call; checks vector and level when one comes.
    task automatic see_call(input logic hit, input logic [15:0] addr,
                            input logic [1:0] lvl);
        logic seen;
        seen = 1'b0;
        repeat (72) begin
            @(posedge hclk);
            if (call.push_pc === 1'b1 && !seen) begin
                seen = 1'b1;
                chk_word({6'h0, call.level, call.vector},
                         {6'h0, lvl, flic_pkg::VEC_PAGE, addr});
            end
        end
        chk_word({31'h0, seen}, {31'h0, hit});
    endtask : see_call

    // Pulses a return from interrupt through the sequencer model.
    task automatic irq_return();
        @(posedge hclk);
        irq_return_req <= 1'b1;
        @(posedge hclk);
        irq_return_req <= 1'b0;
    endtask : irq_return

    // Cuts a hung run short.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            wrap_up();
        end
    end

    // Main sequence of scenarios.
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (regs[i]) rdchk(regs[i], 32'h0);
        bus(8'h10, 1'b1, 32'hff);
        rdchk(8'h10, 32'h0);
        bus(flic_pkg::IDX_ENABLE_A, 1'b1, 32'h01);
        rdchk(flic_pkg::IDX_ENABLE_A, 32'h01);
        pin_a_n <= 1'b0;
        see_call(1'b0, 16'h0, 2'h0);
        slow <= 1'b1;
        bus(flic_pkg::IDX_ENABLE_A, 1'b1, 32'h81);
        see_call(1'b1, 16'h0003, 2'h0);
        rdchk(flic_pkg::IDX_STAT, 32'h01);
        see_call(1'b0, 16'h0, 2'h0);
        pin_a_n <= 1'b1;
        see_call(1'b0, 16'h0, 2'h0);
        irq_return();
        rdchk(flic_pkg::IDX_STAT, 32'h0);
        see_call(1'b0, 16'h0, 2'h0);
        // Two equal requests, then raised levels preempt one by one.
        slow <= 1'b0;
        src.timer_a_overflow_flag <= 1'b1;
        pin_b_n <= 1'b0;
        bus(flic_pkg::IDX_ENABLE_A, 1'b1, 32'h86);
        see_call(1'b1, 16'h000b, 2'h0);
        bus(flic_pkg::IDX_PRIO_LO_A, 1'b1, 32'h04);
        see_call(1'b1, 16'h0013, 2'h1);
        bus(flic_pkg::IDX_PRIO_HI_A, 1'b1, 32'h02);
        see_call(1'b1, 16'h000b, 2'h2);
        bus(flic_pkg::IDX_PRIO_HI_A, 1'b1, 32'h06);
        see_call(1'b1, 16'h0013, 2'h3);
        bus(flic_pkg::IDX_PRIO_LO_A, 1'b1, 32'h06);
        see_call(1'b0, 16'h0, 2'h0);
        rdchk(flic_pkg::IDX_STAT, 32'h0f);
        src.timer_a_overflow_flag <= 1'b0;
        pin_b_n <= 1'b1;
        see_call(1'b0, 16'h0, 2'h0);
        repeat (4) irq_return();
        rdchk(flic_pkg::IDX_STAT, 32'h0);
        // Bus reset at level one on the shared vector.
        bus(flic_pkg::IDX_ENABLE_B, 1'b1, 32'h0c);
        bus(flic_pkg::IDX_PRIO_LO_B, 1'b1, 32'h04);
        @(posedge hclk);
        src.usb_bus_reset <= 1'b1;
        @(posedge hclk);
        src.usb_bus_reset <= 1'b0;
        see_call(1'b1, 16'h0053, 2'h1);
        rdchk(flic_pkg::IDX_STAT, 32'h12);
        bus(flic_pkg::IDX_STAT, 1'b1, 32'h10);
        rdchk(flic_pkg::IDX_STAT, 32'h02);
        irq_return();
        rdchk(flic_pkg::IDX_STAT, 32'h0);
        // Keyboard pin alone at level zero on its own slot.
        bus(flic_pkg::IDX_ENABLE_A, 1'b1, 32'hc0);
        pin_k_n <= 1'b0;
        see_call(1'b1, 16'h0033, 2'h0);
        pin_k_n <= 1'b1;
        wrap_up();
    end
endmodule : tb_four_level_interrupt_controller
`default_nettype wire

// *** logic/flic_ctrl.sv ***
// Four-level interrupt controller with an AHB-Lite register port.
// Assumes sources and sequencer run on hclk; request pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module flic_ctrl (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Active-low request pins.
    input wire logic ext_request_pin_a_n,
    input wire logic ext_request_pin_b_n,
    input wire logic keyboard_request_pin_n,
    // On-chip sources and sequencer.
    input wire flic_pkg::flic_src_s src,
    input wire flic_pkg::flic_cpu_s cpu,
    // Orders to the sequencer and the USB blocks.
    output flic_pkg::flic_call_s call,
    output logic usb_hw_reset,
    output logic [3:0] phase
);

    // Complete state of the controller.
    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] prh_a;
        logic [7:0] prl_a;
        logic [7:0] prh_b;
        logic [7:0] prl_b;
        logic [3:0] ins;
        logic brf;
        logic [3:0] ph;
        logic [2:0] s0;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] pin;
        logic [flic_pkg::NSRC-1:0] samp;
        logic [flic_pkg::NSRC-1:0] poll;
        logic hold;
        flic_pkg::flic_call_e cs;
        logic [1:0] mc;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic push;
        logic pop;
        logic usbrst;
        logic [1:0] lvl;
        logic [23:0] vec;
    } flic_state_s;

    flic_state_s st_r;
    flic_state_s st_nxt;

    // Priority level of one slot.
    function automatic logic [1:0] slot_level(
        input flic_state_s s,
        input int unsigned i
    );
        logic [1:0] l;
        l = 2'h0;
        if (i < 7) begin
            l = {s.prh_a[i], s.prl_a[i]};
        end else if (i > 7) begin
            l = {s.prh_b[i-8], s.prl_b[i-8]};
        end
        return l;
    endfunction : slot_level

    // Own enable of one slot; slot 10 is gated when sampled.
    function automatic logic slot_enable(
        input flic_state_s s,
        input int unsigned i
    );
        logic e;
        e = 1'b0;
        if (i < 7) begin
            e = s.en_a[i];
        end else if (i == 8 || i == 9) begin
            e = s.en_b[i-8];
        end else if (i == flic_pkg::SLOT_GSR) begin
            e = 1'b1;
        end
        return e;
    endfunction : slot_enable

    // Register read decode.
    function automatic logic [7:0] reg_read(
        input flic_state_s s,
        input logic [7:0] idx
    );
        logic [7:0] d;
        d = 8'h00;
        case (idx)
            flic_pkg::IDX_ENABLE_A: d = s.en_a;
            flic_pkg::IDX_ENABLE_B: d = s.en_b;
            flic_pkg::IDX_PRIO_HI_A: d = s.prh_a;
            flic_pkg::IDX_PRIO_LO_A: d = s.prl_a;
            flic_pkg::IDX_PRIO_HI_B: d = s.prh_b;
            flic_pkg::IDX_PRIO_LO_B: d = s.prl_b;
            flic_pkg::IDX_STAT: d = {3'h0, s.brf, s.ins};
            default: d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    // Arbitration over the polled requests.
    logic [flic_pkg::NSRC-1:0] req;
    logic found;
    logic [1:0] best_lvl;
    logic [3:0] best_idx;
    logic [2:0] cur_ext;
    logic accept;

    always_comb begin
        found = 1'b0;
        best_lvl = 2'h0;
        best_idx = 4'h0;
        for (int unsigned i = 0; i < flic_pkg::NSRC; i++) begin
            req[i] = st_r.poll[i] & slot_enable(st_r, i)
                & st_r.en_a[flic_pkg::GIE_BIT];
            if (req[i] && (!found || slot_level(st_r, i) > best_lvl)) begin
                found = 1'b1;
                best_lvl = slot_level(st_r, i);
                best_idx = 4'(i);
            end
        end
        // One above the highest level in service, zero when idle.
        if (st_r.ins[3]) begin
            cur_ext = 3'h4;
        end else if (st_r.ins[2]) begin
            cur_ext = 3'h3;
        end else if (st_r.ins[1]) begin
            cur_ext = 3'h2;
        end else if (st_r.ins[0]) begin
            cur_ext = 3'h1;
        end else begin
            cur_ext = 3'h0;
        end
        accept = found
            && ({1'b0, best_lvl} + 3'h1 > cur_ext)
            && st_r.ph == flic_pkg::PH_LAST
            && cpu.last_cycle
            && !st_r.hold
            && !cpu.return_from_interrupt
            && st_r.cs == flic_pkg::FLIC_IDLE;
    end

    // Bus address phase.
    logic addr_ok;
    logic reg_wr;
    logic prio_wr;

    assign addr_ok = hsel && htrans[1] && hready;
    assign reg_wr = st_r.wr_pend;
    assign prio_wr = reg_wr && st_r.wr_idx != flic_pkg::IDX_STAT;

    // Next-state logic.
    always_comb begin
        st_nxt = st_r;
        st_nxt.push = 1'b0;
        st_nxt.pop = 1'b0;

        // Machine cycle phase counter.
        if (st_r.ph == flic_pkg::PH_LAST) begin
            st_nxt.ph = 4'h0;
        end else begin
            st_nxt.ph = st_r.ph + 4'h1;
        end

        // Pin synchronisers; a change counts when the last two agree.
        st_nxt.s0 = {keyboard_request_pin_n, ext_request_pin_b_n,
            ext_request_pin_a_n};
        st_nxt.s1 = st_r.s0;
        st_nxt.s2 = st_r.s1;
        for (int i = 0; i < 3; i++) begin
            if (st_r.s1[i] == st_r.s2[i]) begin
                st_nxt.pin[i] = st_r.s2[i];
            end
        end

        // Register writes in the data phase.
        st_nxt.wr_pend = addr_ok && hwrite;
        if (addr_ok) begin
            st_nxt.wr_idx = haddr[9:2];
            st_nxt.rdata = {24'h0, reg_read(st_r, haddr[9:2])};
        end
        if (reg_wr) begin
            case (st_r.wr_idx)
                flic_pkg::IDX_ENABLE_A: st_nxt.en_a = hwdata[7:0];
                flic_pkg::IDX_ENABLE_B: st_nxt.en_b = hwdata[7:0];
                flic_pkg::IDX_PRIO_HI_A: st_nxt.prh_a = hwdata[7:0];
                flic_pkg::IDX_PRIO_LO_A: st_nxt.prl_a = hwdata[7:0];
                flic_pkg::IDX_PRIO_HI_B: st_nxt.prh_b = hwdata[7:0];
                flic_pkg::IDX_PRIO_LO_B: st_nxt.prl_b = hwdata[7:0];
                flic_pkg::IDX_STAT: begin
                    if (hwdata[flic_pkg::BRF_BIT]) begin
                        st_nxt.brf = 1'b0;
                    end
                end
                default: st_nxt.wr_idx = st_r.wr_idx;
            endcase
        end

        // Bus reset flag; a new reset wins over a clear.
        if (src.usb_bus_reset) begin
            st_nxt.brf = 1'b1;
        end
        st_nxt.usbrst = src.usb_bus_reset;

        // Sample flags at state five phase two.
        if (st_r.ph == flic_pkg::PH_SAMPLE) begin
            st_nxt.samp[flic_pkg::SLOT_EXT_A] = ~st_r.pin[0];
            st_nxt.samp[1] = src.timer_a_overflow_flag;
            st_nxt.samp[flic_pkg::SLOT_EXT_B] = ~st_r.pin[1];
            st_nxt.samp[3] = src.timer_b_overflow_flag;
            st_nxt.samp[4] = src.serial_rx_flag | src.serial_tx_flag;
            st_nxt.samp[5] = src.timer_c_external_flag;
            st_nxt.samp[flic_pkg::SLOT_KEYB] = ~st_r.pin[2];
            st_nxt.samp[7] = 1'b0;
            st_nxt.samp[8] = src.hub_sof;
            st_nxt.samp[9] = src.usb_function;
            st_nxt.samp[flic_pkg::SLOT_GSR] =
                (src.global_susp_res & st_r.en_b[flic_pkg::GSR_EN_BIT])
                | (st_r.brf & st_r.en_b[flic_pkg::BRIE_BIT]);
        end

        // Samples become the poll set of the next cycle; none are kept.
        if (st_r.ph == flic_pkg::PH_LAST) begin
            st_nxt.poll = st_r.samp;
        end
        // Timer c overflow is taken at state two and polled in that cycle.
        if (st_r.ph == flic_pkg::PH_TIMER_C) begin
            st_nxt.poll[5] = st_r.poll[5] | src.timer_c_overflow_flag;
        end

        // Hold off vectoring until one more instruction has finished.
        if (st_r.ph == flic_pkg::PH_LAST && cpu.last_cycle) begin
            st_nxt.hold = 1'b0;
        end
        if (prio_wr || cpu.return_from_interrupt) begin
            st_nxt.hold = 1'b1;
        end

        // Return from interrupt releases the highest level and pops in the same clock.
        if (cpu.return_from_interrupt) begin
            if (st_r.ins[3]) begin
                st_nxt.ins[3] = 1'b0;
            end else if (st_r.ins[2]) begin
                st_nxt.ins[2] = 1'b0;
            end else if (st_r.ins[1]) begin
                st_nxt.ins[1] = 1'b0;
            end else begin
                st_nxt.ins[0] = 1'b0;
            end
            st_nxt.pop = 1'b1;
        end

        // Hardware call of two machine cycles.
        case (st_r.cs)
            flic_pkg::FLIC_IDLE: begin
                if (accept) begin
                    st_nxt.cs = flic_pkg::FLIC_CALL;
                    st_nxt.mc = flic_pkg::CALL_MC;
                    st_nxt.push = 1'b1;
                    st_nxt.lvl = best_lvl;
                    st_nxt.ins[best_lvl] = 1'b1;
                    st_nxt.vec = {flic_pkg::VEC_PAGE, flic_pkg::VEC_BASE
                        + {9'h0, best_idx, 3'h0}};
                end
            end
            flic_pkg::FLIC_CALL: begin
                if (st_r.ph == flic_pkg::PH_LAST) begin
                    st_nxt.mc = st_r.mc - 2'h1;
                    if (st_r.mc == 2'h1) begin
                        st_nxt.cs = flic_pkg::FLIC_IDLE;
                    end
                end
            end
            default: st_nxt.cs = flic_pkg::FLIC_IDLE;
        endcase
    end

    // State register; reset clears enables, priorities and levels.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.s0 <= 3'h7;
            st_r.s1 <= 3'h7;
            st_r.s2 <= 3'h7;
            st_r.pin <= 3'h7;
            st_r.cs <= flic_pkg::FLIC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign call.long_call = st_r.cs == flic_pkg::FLIC_CALL;
    assign call.push_pc = st_r.push;
    assign call.pop_pc = st_r.pop;
    assign call.level = st_r.lvl;
    assign call.vector = st_r.vec;
    assign usb_hw_reset = st_r.usbrst;
    assign phase = st_r.ph;

endmodule : flic_ctrl

`default_nettype wire

// *** logic/flic_pkg.sv ***
// Shared constants and carrier types of the four-level interrupt controller.
// Assumes a single 125 MHz clock and a 32-bit AHB-Lite register port.
package flic_pkg;

    // Request slots in fixed tie-break order; slot 7 is unused.
    localparam int unsigned NSRC = 11;
    localparam int unsigned SLOT_EXT_A = 0;
    localparam int unsigned SLOT_EXT_B = 2;
    localparam int unsigned SLOT_KEYB = 6;
    localparam int unsigned SLOT_GSR = 10;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_ENABLE_A = 8'ha8;
    localparam logic [7:0] IDX_ENABLE_B = 8'hb1;
    localparam logic [7:0] IDX_PRIO_HI_A = 8'hb7;
    localparam logic [7:0] IDX_PRIO_LO_A = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HI_B = 8'hb5;
    localparam logic [7:0] IDX_PRIO_LO_B = 8'hb6;
    localparam logic [7:0] IDX_STAT = 8'hb9;

    // Field positions.
    localparam int unsigned GIE_BIT = 7;
    localparam int unsigned GSR_EN_BIT = 2;
    localparam int unsigned BRIE_BIT = 3;
    localparam int unsigned BRF_BIT = 4;

    // Machine cycle: six states of two phases each.
    localparam logic [3:0] PH_LAST = 4'hb;
    localparam logic [3:0] PH_SAMPLE = 4'h9;
    localparam logic [3:0] PH_TIMER_C = 4'h3;
    localparam logic [1:0] CALL_MC = 2'h2;

    // Vector layout.
    localparam logic [7:0] VEC_PAGE = 8'hff;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int unsigned VEC_SHIFT = 3;

    // Reset values.
    localparam logic [7:0] REG_RST = 8'h00;

    typedef enum logic {
        FLIC_IDLE = 1'b0,
        FLIC_CALL = 1'b1
    } flic_call_e;

    // Request flags of the on-chip sources.
    typedef struct packed {
        logic timer_a_overflow_flag;
        logic timer_b_overflow_flag;
        logic timer_c_overflow_flag;
        logic timer_c_external_flag;
        logic serial_rx_flag;
        logic serial_tx_flag;
        logic hub_sof;
        logic usb_function;
        logic global_susp_res;
        logic usb_bus_reset;
    } flic_src_s;

    // Status from the instruction sequencer.
    typedef struct packed {
        logic last_cycle;
        logic return_from_interrupt;
    } flic_cpu_s;

    // Orders to the instruction sequencer.
    typedef struct packed {
        logic long_call;
        logic push_pc;
        logic pop_pc;
        logic [1:0] level;
        logic [23:0] vector;
    } flic_call_s;

endpackage : flic_pkg
